// file: hw/i2cbr_top.sv
`timescale 1ns/10ps
// Summary of operation
// - Channel-select parameter that is not a valid channel code is not acknowledged.
// - While busy, command codes that start or change line activity are refused.
// - Read-pointer code C3h is acknowledged and selects the configuration register.
// - An undefined read-pointer code is refused and the pointer is unchanged.
// - Read-pointer code E1h selects the byte last received by read byte.
// - Read pointer may be set during a read byte; data appears when done.
// - Line reset outcome shows in the status register after completion.
// - Status is reloaded for every byte of a read; the host polls busy.
// - Busy flag falls from 1 to 0 when a write byte completes.
// - Write byte sends its parameter and captures nothing from the line.
// - The two-wire clock is only an input; it is never held low.
// - The data pin is only pulled low or released.
// - Command codes F0h, D2h, C3h, E1h, B4h, A5h, 96h, 87h, 78h.
// - Valid codes and expected parameters are acknowledged unless refused while busy; extra bytes never.
// - Read pointer persists across reads until it is set again; each line-operation launch returns it to status.
module i2cbr_top (
  // System
  input wire logic clk,
  input wire logic rst,
  // Two-wire host pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [2:0] addr_pins,
  // Line sequencer, on link_clk
  input wire logic link_clk,
  output logic seq_start,
  output i2cbr_pkg::i2cbr_op_e seq_op,
  output logic [7:0] seq_data,
  output logic [i2cbr_pkg::CHAN_W-1:0] seq_chan,
  input wire logic seq_done,
  input wire logic [7:0] seq_byte,
  input wire logic [i2cbr_pkg::RF_W-1:0] seq_flags,
  // Status
  output logic line_busy_flag
);
  import i2cbr_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WR, ST_ACK, ST_RD, ST_RACK} i2cbr_bus_e;

  typedef struct packed {
    i2cbr_bus_e st;
    logic scl_d;
    logic sda_d;
    logic [7:0] shreg;
    logic [3:0] bcnt;
    logic rw;
    logic mack;
    logic [1:0] idx;
    logic [7:0] cmd;
    logic sda_oe;
    logic [7:0] ptr;
    logic [7:0] cfg;
    logic [CHAN_W-1:0] chan;
    logic busy;
    logic rst_flag;
    logic pd;
    logic sd;
    logic sbr;
    logic tsb;
    logic dir;
    logic [7:0] rdata;
    logic req_tgl;
    i2cbr_op_e req_op;
    logic [7:0] req_data;
    logic [CHAN_W-1:0] req_chan;
    logic ack_seen;
  } i2cbr_top_s;

  function automatic logic cmd_known(logic [7:0] c);
    return c inside {CMD_DEV_RST, CMD_WR_CFG, CMD_CHAN_SEL, CMD_SET_PTR, CMD_LINE_RST,
                     CMD_WR_BYTE, CMD_RD_BYTE, CMD_BIT, CMD_TRIPLET};
  endfunction

  function automatic logic cmd_has_param(logic [7:0] c);
    return c inside {CMD_WR_CFG, CMD_CHAN_SEL, CMD_SET_PTR, CMD_WR_BYTE, CMD_BIT, CMD_TRIPLET};
  endfunction

  function automatic logic cmd_line_op(logic [7:0] c);
    return c inside {CMD_LINE_RST, CMD_WR_BYTE, CMD_RD_BYTE, CMD_BIT, CMD_TRIPLET};
  endfunction

  // Only these leave line activity alone, so they stay legal while busy
  function automatic logic cmd_busy_ok(logic [7:0] c);
    return c inside {CMD_DEV_RST, CMD_SET_PTR};
  endfunction

  // A channel code carries the channel in the low nibble, its inverse above
  function automatic logic chan_ok(logic [7:0] b);
    return (b[2*NIB-1:NIB] == ~b[NIB-1:0]) && !b[NIB-1];
  endfunction

  function automatic logic [7:0] chan_code(logic [CHAN_W-1:0] ch);
    logic [NIB-1:0] lo;
    lo = {1'b0, ch};
    return {~lo, lo};
  endfunction

  function automatic logic ptr_ok(logic [7:0] b);
    return b inside {PTR_STATUS, PTR_DATA, PTR_CHAN, PTR_CFG};
  endfunction

  function automatic i2cbr_op_e op_of(logic [7:0] c);
    case (c)
      CMD_LINE_RST: return OP_RESET;
      CMD_WR_BYTE: return OP_WRITE;
      CMD_RD_BYTE: return OP_READ;
      CMD_BIT: return OP_BIT;
      default: return OP_TRIPLET;
    endcase
  endfunction

  function automatic logic [7:0] status_of(i2cbr_top_s v);
    logic [7:0] r;
    r = '0;
    r[SB_BUSY] = v.busy;
    r[SB_PD] = v.pd;
    r[SB_SD] = v.sd;
    r[SB_RST] = v.rst_flag;
    r[SB_SBR] = v.sbr;
    r[SB_TSB] = v.tsb;
    r[SB_DIR] = v.dir;
    return r;
  endfunction

  function automatic logic [7:0] read_reg(i2cbr_top_s v);
    case (v.ptr)
      PTR_DATA: return v.rdata;
      PTR_CFG: return v.cfg;
      PTR_CHAN: return chan_code(v.chan);
      default: return status_of(v);
    endcase
  endfunction

  i2cbr_top_s s_q, s_d;
  logic [PIN_ADDR+2:0] pin_q;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic ack_q;
  logic done_ev;
  logic wr_end;
  logic [7:0] rd_now;

  i2cbr_xfer_if xf ();

  // Clock pin is sampled only; there is no way to drive it
  i2cbr_sync #(.W(PIN_ADDR+3)) u_pin_sync (
    .clk(clk),
    .d({addr_pins, sda_in, scl_in}),
    .q(pin_q)
  );

  i2cbr_sync #(.W(1)) u_ack_sync (
    .clk(clk),
    .d(xf.ack_tgl),
    .q(ack_q)
  );

  i2cbr_link u_link (
    .rst(rst),
    .xf(xf.link),
    .link_clk(link_clk),
    .seq_start(seq_start),
    .seq_op(seq_op),
    .seq_data(seq_data),
    .seq_chan(seq_chan),
    .seq_done(seq_done),
    .seq_byte(seq_byte),
    .seq_flags(seq_flags)
  );

  assign scl = pin_q[PIN_SCL];
  assign sda = pin_q[PIN_SDA];
  assign scl_rise = scl && !s_q.scl_d;
  assign scl_fall = !scl && s_q.scl_d;
  assign bus_start = scl && s_q.scl_d && s_q.sda_d && !sda;
  assign bus_stop = scl && s_q.scl_d && !s_q.sda_d && sda;
  assign done_ev = ack_q != s_q.ack_seen;
  assign wr_end = s_q.st == ST_WR && scl_fall && s_q.bcnt == BYTE_BITS && !bus_start && !bus_stop;
  assign rd_now = read_reg(s_q);

  always_comb begin
    logic go;
    logic ack;
    logic [7:0] b;
    logic [7:0] gcmd;
    logic [7:0] gdat;
    go = 1'b0;
    ack = 1'b0;
    b = s_q.shreg;
    gcmd = s_q.cmd;
    gdat = '0;
    s_d = s_q;
    s_d.scl_d = scl;
    s_d.sda_d = sda;
    if (done_ev) begin
      s_d.ack_seen = ack_q;
      s_d.busy = 1'b0;
      unique case (s_q.req_op)
        OP_RESET: begin
          s_d.pd = xf.res_flags[RF_PD];
          s_d.sd = xf.res_flags[RF_SD];
        end
        OP_READ: s_d.rdata = xf.res_byte;
        OP_WRITE: s_d.rdata = s_q.rdata;
        OP_BIT: s_d.sbr = xf.res_flags[RF_SBR];
        OP_TRIPLET: begin
          s_d.sbr = xf.res_flags[RF_SBR];
          s_d.tsb = xf.res_flags[RF_TSB];
          s_d.dir = xf.res_flags[RF_DIR];
        end
      endcase
    end
    if (bus_start) begin
      s_d.st = ST_ADDR;
      s_d.bcnt = '0;
      s_d.sda_oe = 1'b0;
    end else if (bus_stop) begin
      s_d.st = ST_IDLE;
      s_d.sda_oe = 1'b0;
    end else begin
      unique case (s_q.st)
        ST_IDLE: s_d.st = ST_IDLE;
        ST_ADDR, ST_WR: begin
          if (scl_rise) begin
            s_d.shreg = {s_q.shreg[MSB-1:0], sda};
            s_d.bcnt = s_q.bcnt + 4'h1;
          end else if (scl_fall && s_q.bcnt == BYTE_BITS) begin
            if (s_q.st == ST_ADDR) begin
              ack = b[MSB:1] == {ADDR_HI, pin_q[PIN_ADDR+2:PIN_ADDR]};
              s_d.rw = b[0];
              s_d.idx = IDX_CMD;
            end else begin
              unique case (s_q.idx)
                IDX_CMD: begin
                  ack = cmd_known(b) && (!s_q.busy || cmd_busy_ok(b));
                  if (ack) begin
                    s_d.cmd = b;
                    s_d.idx = IDX_PAR;
                    gcmd = b;
                    go = cmd_line_op(b) && !cmd_has_param(b);
                    if (b == CMD_DEV_RST) begin
                      s_d.cfg = '0;
                      s_d.chan = '0;
                      s_d.ptr = PTR_STATUS;
                      s_d.rst_flag = 1'b1;
                    end
                  end
                end
                IDX_PAR: begin
                  ack = cmd_has_param(s_q.cmd);
                  if (s_q.cmd == CMD_CHAN_SEL) begin
                    ack = chan_ok(b);
                  end
                  if (s_q.cmd == CMD_SET_PTR) begin
                    ack = ptr_ok(b);
                  end
                  if (ack) begin
                    s_d.idx = IDX_MORE;
                    gdat = b;
                    go = cmd_line_op(s_q.cmd);
                    if (s_q.cmd == CMD_CHAN_SEL) begin
                      s_d.chan = b[CHAN_W-1:0];
                    end
                    if (s_q.cmd == CMD_SET_PTR) begin
                      s_d.ptr = b;
                    end
                    if (s_q.cmd == CMD_WR_CFG) begin
                      s_d.cfg = b;
                      s_d.rst_flag = 1'b0;
                    end
                  end
                end
                default: ack = 1'b0;
              endcase
            end
            s_d.sda_oe = ack;
            // After a refusal, idle until the host restarts
            s_d.st = ack ? ST_ACK : ST_IDLE;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            s_d.bcnt = '0;
            if (s_q.rw) begin
              s_d.shreg = rd_now;
              s_d.sda_oe = !rd_now[MSB];
              s_d.st = ST_RD;
            end else begin
              s_d.sda_oe = 1'b0;
              s_d.st = ST_WR;
            end
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            s_d.bcnt = s_q.bcnt + 4'h1;
            s_d.shreg = {s_q.shreg[MSB-1:0], 1'b0};
            if (s_q.bcnt == LAST_BIT) begin
              s_d.sda_oe = 1'b0;
              s_d.st = ST_RACK;
            end else begin
              s_d.sda_oe = !s_q.shreg[MSB-1];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            s_d.mack = !sda;
          end else if (scl_fall) begin
            if (s_q.mack) begin
              s_d.shreg = rd_now;
              s_d.sda_oe = !rd_now[MSB];
              s_d.bcnt = '0;
              s_d.st = ST_RD;
            end else begin
              s_d.st = ST_IDLE;
            end
          end
        end
      endcase
    end
    // Launch wins over a completion seen in the same cycle
    if (go) begin
      s_d.busy = 1'b1;
      s_d.req_tgl = ~s_q.req_tgl;
      s_d.req_op = op_of(gcmd);
      s_d.req_data = gdat;
      s_d.req_chan = s_q.chan;
      s_d.ptr = PTR_STATUS;
    end
    if (rst) begin
      s_d = '0;
      s_d.ptr = PTR_STATUS;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign sda_out = 1'b0;
  assign sda_oe = s_q.sda_oe;
  assign line_busy_flag = s_q.busy;
  assign xf.req_tgl = s_q.req_tgl;
  assign xf.req_op = s_q.req_op;
  assign xf.req_data = s_q.req_data;
  assign xf.req_chan = s_q.req_chan;

  // Pointer about to move; lets the persistence check allow a launch
  logic go_any;
  assign go_any = s_d.ptr != s_q.ptr;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence cmd_end;
    wr_end && s_q.idx == IDX_CMD;
  endsequence
  sequence par_end;
    wr_end && s_q.idx == IDX_PAR;
  endsequence
  sequence read_next;
    s_q.st == ST_RACK && scl_fall && s_q.mack && !bus_start && !bus_stop;
  endsequence

  a_busy_cmd_nack: assert property (cmd_end ##0 (s_q.busy && !cmd_busy_ok(s_q.shreg)) |=> !s_q.sda_oe)
    else $error("command acknowledged while busy");
  a_chan_bad_nack: assert property (par_end ##0 (s_q.cmd == CMD_CHAN_SEL && !chan_ok(s_q.shreg))
    |=> !s_q.sda_oe && $stable(s_q.chan))
    else $error("bad channel code acknowledged");
  a_ptr_cfg_take: assert property (par_end ##0 (s_q.cmd == CMD_SET_PTR && s_q.shreg == PTR_CFG)
    |=> s_q.sda_oe && s_q.ptr == PTR_CFG)
    else $error("configuration pointer not taken");
  a_ptr_bad_keep: assert property (par_end ##0 (s_q.cmd == CMD_SET_PTR && !ptr_ok(s_q.shreg))
    |=> !s_q.sda_oe && $stable(s_q.ptr))
    else $error("bad pointer code changed pointer");
  a_ptr_busy_ok: assert property (cmd_end ##0 (s_q.busy && s_q.shreg == CMD_SET_PTR) |=> s_q.sda_oe)
    else $error("pointer command refused while busy");
  a_extra_nack: assert property (wr_end && s_q.idx == IDX_MORE |=> !s_q.sda_oe ##1 s_q.st == ST_IDLE)
    else $error("extra byte acknowledged");
  a_read_refresh: assert property (read_next |=> s_q.st == ST_RD && s_q.shreg == $past(rd_now)
    && $stable(s_q.ptr))
    else $error("read byte not refreshed");
  a_write_done: assert property (done_ev && s_q.req_op == OP_WRITE |=> !s_q.busy && $stable(s_q.rdata))
    else $error("write byte completion wrong");
  a_read_data: assert property (done_ev && s_q.req_op == OP_READ |=> s_q.rdata == $past(xf.res_byte)
    && !line_busy_flag)
    else $error("received byte not stored");
  a_reset_status: assert property (done_ev && s_q.req_op == OP_RESET
    |=> s_q.pd == $past(xf.res_flags[RF_PD]) && s_q.sd == $past(xf.res_flags[RF_SD]))
    else $error("reset outcome missing from status");
  a_stop_release: assert property (bus_stop |=> !sda_oe ##1 !sda_oe)
    else $error("data pin held after stop");
  a_ptr_persist: assert property (s_q.st == ST_RD |-> s_q.ptr == $past(s_q.ptr) || $past(go_any))
    else $error("pointer moved during read");
endmodule

// file: common/i2cbr_pkg.sv
package i2cbr_pkg;
  // Command codes on the two-wire side
  localparam logic [7:0] CMD_DEV_RST = 8'hF0;
  localparam logic [7:0] CMD_WR_CFG = 8'hD2;
  localparam logic [7:0] CMD_CHAN_SEL = 8'hC3;
  localparam logic [7:0] CMD_SET_PTR = 8'hE1;
  localparam logic [7:0] CMD_LINE_RST = 8'hB4;
  localparam logic [7:0] CMD_WR_BYTE = 8'hA5;
  localparam logic [7:0] CMD_RD_BYTE = 8'h96;
  localparam logic [7:0] CMD_BIT = 8'h87;
  localparam logic [7:0] CMD_TRIPLET = 8'h78;
  // Read pointer codes
  localparam logic [7:0] PTR_STATUS = 8'hF0;
  localparam logic [7:0] PTR_DATA = 8'hE1;
  localparam logic [7:0] PTR_CHAN = 8'hD2;
  localparam logic [7:0] PTR_CFG = 8'hC3;
  // Upper slave address bits; pins give the lower three
  localparam logic [3:0] ADDR_HI = 4'h3;
  // Byte and code layout
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam int MSB = 7;
  localparam int NIB = 4;
  localparam int CHAN_W = 3;
  // Synchronised pin vector
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_ADDR = 2;
  // Write transfer byte index
  localparam logic [1:0] IDX_CMD = 2'h0;
  localparam logic [1:0] IDX_PAR = 2'h1;
  localparam logic [1:0] IDX_MORE = 2'h2;
  // Status byte bits
  localparam int SB_BUSY = 0;
  localparam int SB_PD = 1;
  localparam int SB_SD = 2;
  localparam int SB_RST = 4;
  localparam int SB_SBR = 5;
  localparam int SB_TSB = 6;
  localparam int SB_DIR = 7;
  // Result flags returned by the sequencer
  localparam int RF_PD = 0;
  localparam int RF_SD = 1;
  localparam int RF_SBR = 2;
  localparam int RF_TSB = 3;
  localparam int RF_DIR = 4;
  localparam int RF_W = 5;
  typedef enum logic [2:0] {OP_RESET, OP_WRITE, OP_READ, OP_BIT, OP_TRIPLET} i2cbr_op_e;
endpackage

// file: common/i2cbr_xfer_if.sv
`timescale 1ns/10ps
interface i2cbr_xfer_if;
  import i2cbr_pkg::*;
  // Request, held stable from its toggle until the answer toggle
  logic req_tgl;
  i2cbr_op_e req_op;
  logic [7:0] req_data;
  logic [CHAN_W-1:0] req_chan;
  // Answer, held stable from its toggle until the next request
  logic ack_tgl;
  logic [7:0] res_byte;
  logic [RF_W-1:0] res_flags;
  modport core (output req_tgl, req_op, req_data, req_chan, input ack_tgl, res_byte, res_flags);
  modport link (input req_tgl, req_op, req_data, req_chan, output ack_tgl, res_byte, res_flags);
endinterface

// file: hw/i2cbr_sync.sv
`timescale 1ns/10ps
module i2cbr_sync #(
  parameter int W = 1
) (
  // Destination clock
  input wire logic clk,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } i2cbr_sync_s;
  i2cbr_sync_s s_q, s_d;
  always_comb begin
    s_d.meta = d;
    s_d.stable = s_q.meta;
  end
  always_ff @(posedge clk) begin
    s_q <= s_d;
  end
  assign q = s_q.stable;
endmodule

// file: hw/i2cbr_link.sv
`timescale 1ns/10ps
module i2cbr_link (
  // Core side
  input wire logic rst,
  i2cbr_xfer_if.link xf,
  // Sequencer, on link_clk
  input wire logic link_clk,
  output logic seq_start,
  output i2cbr_pkg::i2cbr_op_e seq_op,
  output logic [7:0] seq_data,
  output logic [i2cbr_pkg::CHAN_W-1:0] seq_chan,
  input wire logic seq_done,
  input wire logic [7:0] seq_byte,
  input wire logic [i2cbr_pkg::RF_W-1:0] seq_flags
);
  import i2cbr_pkg::*;
  typedef struct packed {
    logic seen;
    logic busy;
    logic start;
    i2cbr_op_e op;
    logic [7:0] data;
    logic [CHAN_W-1:0] chan;
    logic ack_tgl;
    logic [7:0] res;
    logic [RF_W-1:0] flags;
  } i2cbr_link_s;
  i2cbr_link_s l_q, l_d;
  logic [1:0] sy;
  logic link_rst;
  logic req_t;
  // Reset and request toggle are levels from the core clock
  i2cbr_sync #(.W(2)) u_sync (.clk(link_clk), .d({xf.req_tgl, rst}), .q(sy));
  assign link_rst = sy[0];
  assign req_t = sy[1];
  always_comb begin
    l_d = l_q;
    l_d.start = 1'b0;
    if (l_q.busy && seq_done) begin
      l_d.busy = 1'b0;
      l_d.res = seq_byte;
      l_d.flags = seq_flags;
      l_d.ack_tgl = ~l_q.ack_tgl;
    end
    // Payload is safe to read: the core holds it until the answer toggles
    if (req_t != l_q.seen) begin
      l_d.seen = req_t;
      l_d.busy = 1'b1;
      l_d.start = 1'b1;
      l_d.op = xf.req_op;
      l_d.data = xf.req_data;
      l_d.chan = xf.req_chan;
    end
    if (link_rst) begin
      l_d = '0;
    end
  end
  always_ff @(posedge link_clk) begin
    l_q <= l_d;
  end
  assign seq_start = l_q.start;
  assign seq_op = l_q.op;
  assign seq_data = l_q.data;
  assign seq_chan = l_q.chan;
  assign xf.ack_tgl = l_q.ack_tgl;
  assign xf.res_byte = l_q.res;
  assign xf.res_flags = l_q.flags;
  a_start_single: assert property (@(posedge link_clk) disable iff (link_rst)
    seq_start |=> !seq_start && l_q.busy)
    else $error("sequencer start longer than one cycle");
endmodule

// file: verif/i2cbr_seq_model.sv
`timescale 1ns/10ps
module i2cbr_seq_model (
  // Sequencer requests
  input wire logic link_clk,
  input wire logic seq_start,
  input wire i2cbr_pkg::i2cbr_op_e seq_op,
  input wire logic [7:0] seq_data,
  // Bench controls
  input wire logic [15:0] lat,
  input wire logic [7:0] resp_byte,
  input wire logic [i2cbr_pkg::RF_W-1:0] resp_flags,
  // Answers
  output logic seq_done,
  output logic [7:0] seq_byte,
  output logic [i2cbr_pkg::RF_W-1:0] seq_flags,
  output i2cbr_pkg::i2cbr_op_e got_op,
  output logic [7:0] got_data
);
  import i2cbr_pkg::*;
  initial begin
    seq_done = 1'b0;
    seq_byte = 8'h00;
    seq_flags = '0;
    got_op = OP_RESET;
    got_data = 8'h00;
  end
  // One op at a time; latency set by the bench so busy can be watched
  always @(posedge link_clk) begin
    if (seq_start === 1'b1) begin
      got_op <= seq_op;
      got_data <= seq_data;
      repeat (lat) @(posedge link_clk);
      seq_done <= 1'b1;
      seq_byte <= resp_byte;
      seq_flags <= resp_flags;
      @(posedge link_clk);
      // Results are only valid with done, so scramble them afterwards
      seq_done <= 1'b0;
      seq_byte <= ~resp_byte;
      seq_flags <= ~resp_flags;
    end
  end
endmodule

// file: verif/tb_i2cbr_top.sv
`timescale 1ns/10ps
module tb_i2cbr_top;
  import i2cbr_pkg::*;
  logic clk, link_clk, rst, scl_m, sda_m, sda_w, sda_out, sda_oe, seq_start, seq_done, line_busy_flag;
  i2cbr_op_e seq_op, got_op;
  logic [7:0] seq_data, seq_byte, got_data, resp_byte, rb;
  logic [15:0] lat;
  logic [CHAN_W-1:0] seq_chan;
  logic [RF_W-1:0] seq_flags, resp_flags;
  logic [2:0] ak;
  int n_mismatch, checks, k;
  // Pull-up on the data line; the clock is never driven by the slave
  assign sda_w = sda_m & ~sda_oe;
  i2cbr_top i2cbr_top_inst (.clk(clk), .rst(rst), .scl_in(scl_m), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_pins(3'h5), .link_clk(link_clk), .seq_start(seq_start), .seq_op(seq_op),
    .seq_data(seq_data), .seq_chan(seq_chan), .seq_done(seq_done), .seq_byte(seq_byte),
    .seq_flags(seq_flags), .line_busy_flag(line_busy_flag));
  i2cbr_seq_model i2cbr_seq_model_inst (.link_clk(link_clk), .seq_start(seq_start), .seq_op(seq_op),
    .seq_data(seq_data), .lat(lat), .resp_byte(resp_byte), .resp_flags(resp_flags), .seq_done(seq_done),
    .seq_byte(seq_byte), .seq_flags(seq_flags), .got_op(got_op), .got_data(got_data));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever #40 link_clk = ~link_clk;
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wbit(input logic b);
    sda_m <= b;
    tick(5);
    scl_m <= 1'b1;
    tick(10);
    scl_m <= 1'b0;
    tick(5);
  endtask
  task automatic rbit(output logic b);
    sda_m <= 1'b1;
    tick(5);
    scl_m <= 1'b1;
    tick(5);
    #1 b = sda_w;
    tick(5);
    scl_m <= 1'b0;
    tick(5);
  endtask
  task automatic wbyte(input logic [7:0] v, output logic a);
    logic b;
    for (int i = MSB; i >= 0; i--) wbit(v[i]);
    rbit(b);
    a = ~b;
  endtask
  task automatic rbyte(input logic more, output logic [7:0] v);
    for (int i = MSB; i >= 0; i--) rbit(v[i]);
    wbit(~more);
  endtask
  task automatic start;
    sda_m <= 1'b1;
    scl_m <= 1'b1;
    tick(5);
    sda_m <= 1'b0;
    tick(5);
    scl_m <= 1'b0;
    tick(5);
  endtask
  task automatic stop;
    sda_m <= 1'b0;
    tick(5);
    scl_m <= 1'b1;
    tick(5);
    sda_m <= 1'b1;
    tick(5);
  endtask
  // host stops at the first refused byte
  task automatic wr(input int n, input logic [7:0] c, input logic [7:0] p, input logic [7:0] x);
    logic [7:0] bs[3];
    logic g;
    bs = '{c, p, x};
    ak = 3'h0;
    start;
    wbyte({ADDR_HI, 3'h5, 1'b0}, g);
    for (int i = 0; i < n && g; i++) begin
      wbyte(bs[i], g);
      ak[i] = g;
    end
    stop;
  endtask
  task automatic rd1;
    logic g;
    start;
    wbyte({ADDR_HI, 3'h5, 1'b1}, g);
    rbyte(1'b0, rb);
    stop;
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 20000 && line_busy_flag !== 1'b0; i++) tick(1);
  endtask
  task automatic t_chan;
    wr(2, CMD_CHAN_SEL, 8'hE5, 8'h00);
    chk("bad channel", {5'h0, ak}, 8'h01);
    wr(3, CMD_CHAN_SEL, 8'hE1, 8'h00);
    chk("extra byte", {5'h0, ak}, 8'h03);
    wr(2, CMD_SET_PTR, PTR_CHAN, 8'h00);
    rd1;
    chk("channel", rb, 8'hE1);
    wr(2, CMD_SET_PTR, 8'hE5, 8'h00);
    chk("bad pointer", {5'h0, ak}, 8'h01);
    rd1;
    chk("pointer kept", rb, 8'hE1);
    wr(2, CMD_SET_PTR, PTR_CFG, 8'h00);
    chk("cfg pointer ack", {5'h0, ak}, 8'h03);
    rd1;
    chk("cfg", rb, 8'h00);
  endtask
  task automatic t_read;
    lat <= 16'd300;
    resp_byte <= 8'hC6;
    wr(1, CMD_RD_BYTE, 8'h00, 8'h00);
    wr(2, CMD_SET_PTR, PTR_DATA, 8'h00);
    chk("pointer while busy", {5'h0, ak}, 8'h03);
    chk("busy in read", {7'h0, line_busy_flag}, 8'h01);
    wait_idle;
    rd1;
    chk("read data", rb, 8'hC6);
    chk("read chan", {5'h0, seq_chan}, 8'h01);
    chk("read op", {5'h0, got_op}, {5'h0, OP_READ});
  endtask
  task automatic t_write;
    logic [7:0] refused[5];
    refused = '{CMD_CHAN_SEL, CMD_LINE_RST, CMD_WR_BYTE, CMD_TRIPLET, CMD_WR_CFG};
    lat <= 16'd1000;
    resp_byte <= 8'h5A;
    wr(2, CMD_WR_BYTE, 8'h33, 8'h00);
    chk("write ack", {5'h0, ak}, 8'h03);
    chk("busy set", {7'h0, line_busy_flag}, 8'h01);
    foreach (refused[i]) begin
      wr(2, refused[i], 8'hF0, 8'h00);
      chk("refused while busy", {5'h0, ak}, 8'h00);
    end
    poll;
    chk("write op", {5'h0, got_op}, {5'h0, OP_WRITE});
    chk("write data", got_data, 8'h33);
    wr(2, CMD_SET_PTR, PTR_DATA, 8'h00);
    rd1;
    chk("data untouched", rb, 8'hC6);
  endtask
  // status polled within one read until busy clears
  task automatic poll;
    logic g;
    start;
    wbyte({ADDR_HI, 3'h5, 1'b1}, g);
    k = 0;
    rb = 8'h01;
    while (rb[SB_BUSY] !== 1'b0 && k < 60) begin
      rbyte(1'b1, rb);
      k++;
    end
    rbyte(1'b0, rb);
    stop;
    chk("busy seen then clear", {7'h0, k > 1}, 8'h01);
    chk("busy after poll", {7'h0, rb[SB_BUSY]}, 8'h00);
  endtask
  task automatic t_lrst;
    lat <= 16'd40;
    resp_flags <= 5'h01;
    wr(1, CMD_LINE_RST, 8'h00, 8'h00);
    // host stays idle until the op is done
    wait_idle;
    rd1;
    chk("reset outcome", rb & 8'h07, 8'h02);
  endtask
  task automatic t_ops;
    logic [7:0] cm[2];
    i2cbr_op_e op[2];
    cm = '{CMD_BIT, CMD_TRIPLET};
    op = '{OP_BIT, OP_TRIPLET};
    foreach (cm[i]) begin
      wr(2, cm[i], 8'h80, 8'h00);
      chk("op ack", {5'h0, ak}, 8'h03);
      wait_idle;
      chk("op code", {5'h0, got_op}, {5'h0, op[i]});
      chk("op data", got_data, 8'h80);
    end
    wr(1, CMD_DEV_RST, 8'h00, 8'h00);
    rd1;
    chk("device reset flag", {7'h0, rb[SB_RST]}, 8'h01);
  endtask
  task automatic wrap_up;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #500000;
    n_mismatch++;
    wrap_up;
  end
  initial begin
    rst = 1'b1;
    scl_m = 1'b1;
    sda_m = 1'b1;
    lat = 16'd4;
    resp_byte = 8'h00;
    resp_flags = '0;
    n_mismatch = 0;
    checks = 0;
    // Longer than ten cycles so the link side sees reset too
    tick(30);
    rst <= 1'b0;
    tick(10);
    chk("busy at reset", {7'h0, line_busy_flag}, 8'h00);
    chk("sda at reset", {7'h0, sda_oe}, 8'h00);
    t_chan;
    t_read;
    t_write;
    t_lrst;
    t_ops;
    chk("sda value", {7'h0, sda_out}, 8'h00);
    wrap_up;
  end
endmodule
